// [rtl/dual_supply_reset_sequencer.sv]
`timescale 1ns/100ps
module dual_supply_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = RELEASE_CYCLES,
    parameter int unsigned TIMER_W        = 23
) (
    input  wire logic clk,
    input  wire logic rst_n,
    // Comparator results, 1 = above threshold; deep flags qualify a low sample
    input  wire logic master_ok,
    input  wire logic master_deep_low,
    input  wire logic secondary_monitor_input,
    input  wire logic secondary_deep_low,
    // Manual reset, active low; an open input idles high
    input  wire logic manual_reset_n,
    // Delay method select and the ramp comparator result
    input  wire logic delay_select_pin,
    input  wire logic ramp_reached,
    // Reset outputs and the ramp current source enable
    output logic      primary_reset_n,
    output logic      secondary_reset_n,
    output logic      ramp_charge_en
);

    // Refuse timer settings that the counters cannot hold
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (64'd1 << TIMER_W)) begin : g_bad_timer
        $error("TIMEOUT_CYCLES does not fit TIMER_W");
    end
    if (ASSERT_SKEW_CYCLES >= (1 << SKEW_W) || SUPPLY_FILTER_CYCLES >= (1 << FILT_W)) begin : g_bad_w
        $error("Filter or skew count does not fit its counter");
    end
    // A zero-length window would underflow its last-count constant
    if (SUPPLY_FILTER_CYCLES < 1 || DEEP_FILTER_CYCLES < 1 ||
        MANUAL_FILTER_CYCLES < 1 || ASSERT_SKEW_CYCLES < 1) begin : g_bad_zero
        $error("Filter and skew windows need at least one cycle");
    end
    // A deep dip must never be tolerated longer than a shallow one
    if (DEEP_FILTER_CYCLES > SUPPLY_FILTER_CYCLES) begin : g_bad_deep
        $error("Deep dip window exceeds the shallow dip window");
    end
    // Deep and manual windows share the filter counter width
    if (DEEP_FILTER_CYCLES >= (1 << FILT_W) ||
        MANUAL_FILTER_CYCLES >= (1 << FILT_W)) begin : g_bad_f
        $error("Deep or manual filter count does not fit its counter");
    end
    // The release timers need a sensible width
    if (TIMER_W < 1 || TIMER_W > 32) begin : g_bad_tw
        $error("TIMER_W out of range");
    end

    localparam logic [TIMER_W-1:0] TIMEOUT_LAST = TIMER_W'(TIMEOUT_CYCLES - 1);
    localparam logic [FILT_W-1:0]  SUP_LAST     = FILT_W'(SUPPLY_FILTER_CYCLES - 1);
    localparam logic [FILT_W-1:0]  DEEP_LAST    = FILT_W'(DEEP_FILTER_CYCLES - 1);
    localparam logic [FILT_W-1:0]  MAN_LAST     = FILT_W'(MANUAL_FILTER_CYCLES - 1);
    localparam logic [SKEW_W-1:0]  SKEW_LAST    = SKEW_W'(ASSERT_SKEW_CYCLES - 1);

    // Timing at a glance, counted in rising edges of clk:
    //   Master comparator low for SUP_LAST+1 samples in a row sets master_bad;
    //   with the deep flag up the same happens after DEEP_LAST+1 samples.
    //   A single good sample clears the flag and the run count together,
    //   so a dip shorter than the window leaves no trace at all.
    //   The secondary comparator uses the same windows and the same scheme.
    //   Manual reset low for MAN_LAST+1 samples sets manual_on.
    //   The secondary reset falls on the edge after any fault flag sets.
    //   The primary reset falls SKEW_LAST+1 edges after a master or manual
    //   flag, and only if that flag still holds; a shorter fault never reaches it.
    //   The primary reset rises TIMEOUT_LAST+1 edges after its flags clear.
    //   Secondary timing starts on the edge after the primary is released and
    //   every fault is clear; fixed mode then counts TIMEOUT_CYCLES edges.
    //   Ramp mode raises the charge enable and waits for the comparator trip.
    //
    // Hazards the scheme avoids:
    //   The secondary can never rise while the primary is still held, since
    //   its timer is cleared on every edge that sees the primary low.
    //   The primary can never fall first, since the secondary falls on the first
    //   edge that sees the fault and the skew counter needs SKEW_LAST+1 edges.
    //   Every timer restarts from zero when its release condition drops,
    //   so a supply that bounces near threshold cannot shorten a timeout.
    //
    // Limitations a user must know:
    //   All windows are whole clock cycles; the package constants assume a
    //   50 MHz clock, so a slower clock stretches every window.
    //   The comparators are taken as already synchronous to clk;
    //   asynchronous pins need a synchroniser in front of this block.
    //   Changing the delay pin mid-timeout switches the method at once.

    // State fields:
    //   m_filt, s_filt   run length of a low comparator sample
    //   master_bad       master supply fault after filtering
    //   sec_bad          secondary input fault after filtering
    //   mr_filt          run length of a low manual reset sample
    //   manual_on        manual reset accepted after glitch rejection
    //   fixed_mode       registered delay pin, 1 selects the counter delay
    //   skew_cnt         lag of the primary behind the secondary on assertion
    //   p_cnt, s_cnt     release timers of the primary and the secondary
    //   prim_n, sec_n    the two reset outputs, active low
    //   charge           current source enable for the external ramp
    typedef struct packed {
        logic [FILT_W-1:0]  m_filt;
        logic               master_bad;
        logic [FILT_W-1:0]  s_filt;
        logic               sec_bad;
        logic [FILT_W-1:0]  mr_filt;
        logic               manual_on;
        logic               fixed_mode;
        logic [SKEW_W-1:0]  skew_cnt;
        logic [TIMER_W-1:0] p_cnt;
        logic               prim_n;
        logic [TIMER_W-1:0] s_cnt;
        logic               sec_n;
        logic               charge;
    } state_s;

    // Value after logic reset: both resets asserted, counters idle, fixed mode
    localparam state_s ST_INIT = '{
        m_filt:     '0,
        master_bad: 1'b0,
        s_filt:     '0,
        sec_bad:    1'b0,
        mr_filt:    '0,
        manual_on:  1'b0,
        fixed_mode: FIXED_MODE_INIT,
        skew_cnt:   '0,
        p_cnt:      '0,
        prim_n:     RESET_ASSERTED,
        s_cnt:      '0,
        sec_n:      RESET_ASSERTED,
        charge:     1'b0
    };

    state_s st_r;
    state_s st_nxt;

    logic prim_fault;
    logic sec_fault;

    // Faults: primary sees master and manual only; secondary sees everything.
    // Keeping the secondary input out of prim_fault is what lets a
    // secondary brownout pass without disturbing the processor reset.
    assign prim_fault = st_r.master_bad | st_r.manual_on;
    assign sec_fault  = prim_fault | st_r.sec_bad;

    always_comb begin
        st_nxt = st_r;

        // Master filter: a dip must outlast the window; deep dips get a shorter one.
        // The count holds at the window end while the flag is set, so a long
        // outage costs no wrap-around and the flag cannot drop by itself.
        if (master_ok) begin
            st_nxt.m_filt     = '0;
            st_nxt.master_bad = 1'b0;
        end else if ((master_deep_low && st_r.m_filt >= DEEP_LAST) ||
                     st_r.m_filt >= SUP_LAST) begin
            st_nxt.master_bad = 1'b1;
        end else begin
            st_nxt.m_filt = st_r.m_filt + FILT_W'(1);
        end

        // Secondary input filter, same scheme.
        // Its flag feeds only the secondary fault, never the primary.
        if (secondary_monitor_input) begin
            st_nxt.s_filt  = '0;
            st_nxt.sec_bad = 1'b0;
        end else if ((secondary_deep_low && st_r.s_filt >= DEEP_LAST) ||
                     st_r.s_filt >= SUP_LAST) begin
            st_nxt.sec_bad = 1'b1;
        end else begin
            st_nxt.s_filt = st_r.s_filt + FILT_W'(1);
        end

        // Manual reset with glitch rejection; an open input idles high.
        // Pulses shorter than the window are dropped so that noise on a
        // long trace to a push button cannot reset the system.
        if (manual_reset_n) begin
            st_nxt.mr_filt   = '0;
            st_nxt.manual_on = 1'b0;
        end else if (st_r.mr_filt >= MAN_LAST) begin
            st_nxt.manual_on = 1'b1;
        end else begin
            st_nxt.mr_filt = st_r.mr_filt + FILT_W'(1);
        end

        // Delay mode follows the pin; a change switches the method at once.
        // The pin is a static strap in practice, so no filter is spent on it.
        st_nxt.fixed_mode = delay_select_pin;

        // Primary: assert after the skew lag so the secondary always leads.
        // A fault that clears within the lag leaves the primary released;
        // that trades a little reaction time for a guaranteed order.
        if (prim_fault) begin
            st_nxt.p_cnt = '0;
            if (!st_r.prim_n) begin
                st_nxt.skew_cnt = '0;
            end else if (st_r.skew_cnt >= SKEW_LAST) begin
                st_nxt.prim_n   = RESET_ASSERTED;
                st_nxt.skew_cnt = '0;
            end else begin
                st_nxt.skew_cnt = st_r.skew_cnt + SKEW_W'(1);
            end
        end else begin
            st_nxt.skew_cnt = '0;
            if (!st_r.prim_n) begin
                if (st_r.p_cnt >= TIMEOUT_LAST) begin
                    st_nxt.prim_n = 1'b1;
                end else begin
                    st_nxt.p_cnt = st_r.p_cnt + TIMER_W'(1);
                end
            end
        end

        // Secondary: drop at once on any fault, time out only behind the primary.
        // While held here the capacitor is discharged, so every ramp delay
        // starts from an empty capacitor and has its full length.
        if (sec_fault || !st_r.prim_n) begin
            st_nxt.sec_n  = sec_fault ? RESET_ASSERTED : st_r.sec_n;
            st_nxt.s_cnt  = '0;
            st_nxt.charge = 1'b0;                                      // Discharges the capacitor
            if (sec_fault) begin
                st_nxt.sec_n = RESET_ASSERTED;
            end
        end else if (!st_r.sec_n) begin
            if (st_r.fixed_mode) begin
                st_nxt.charge = 1'b0;
                if (st_r.s_cnt >= TIMEOUT_LAST) begin
                    st_nxt.sec_n = 1'b1;
                end else begin
                    st_nxt.s_cnt = st_r.s_cnt + TIMER_W'(1);
                end
            end else begin
                // Ramp runs while charging; comparator trip ends the delay
                st_nxt.charge = 1'b1;
                if (st_r.charge && ramp_reached) begin
                    st_nxt.sec_n  = 1'b1;
                    st_nxt.charge = 1'b0;
                end
            end
        end else begin
            st_nxt.charge = 1'b0;
        end
    end

    // State register; every output is a bit of it.
    // Reset loads a constant, so both outputs come up asserted.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= ST_INIT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flip-flops: no glitch can reach a reset pin
    assign primary_reset_n   = st_r.prim_n;
    assign secondary_reset_n = st_r.sec_n;
    assign ramp_charge_en    = st_r.charge;

endmodule

// [rtl/reset_seq_pkg.sv]
package reset_seq_pkg;

    // Sampling clock
    localparam int unsigned CLK_MHZ = 50;

    // Release timeouts, primary and fixed secondary (least time, ms)
    localparam int unsigned RELEASE_TIMEOUT_MS = 140;
    localparam int unsigned RELEASE_CYCLES     = RELEASE_TIMEOUT_MS * CLK_MHZ * 1000;

    // Lead of the secondary reset over the primary one on assertion (us)
    localparam int unsigned ASSERT_SKEW_US     = 10;
    localparam int unsigned ASSERT_SKEW_CYCLES = ASSERT_SKEW_US * CLK_MHZ;

    // Least time a supply comparator must report low before it counts (ns)
    localparam int unsigned SUPPLY_FILTER_NS     = 2000;
    localparam int unsigned SUPPLY_FILTER_CYCLES = (SUPPLY_FILTER_NS * CLK_MHZ + 999) / 1000;

    // Dip on a supply that counts as deep: tolerated for a shorter time (ns)
    localparam int unsigned DEEP_FILTER_NS     = 500;
    localparam int unsigned DEEP_FILTER_CYCLES = (DEEP_FILTER_NS * CLK_MHZ + 999) / 1000;

    // Glitch rejection on the manual reset input (ns)
    localparam int unsigned MANUAL_FILTER_NS     = 100;
    localparam int unsigned MANUAL_FILTER_CYCLES = (MANUAL_FILTER_NS * CLK_MHZ + 999) / 1000;

    // Widths of the small counters
    localparam int unsigned FILT_W = 8;
    localparam int unsigned SKEW_W = 10;

    // Values after reset
    localparam logic RESET_ASSERTED  = 1'b0;
    localparam logic FIXED_MODE_INIT = 1'b1;

endpackage

// [verification/dual_supply_reset_sequencer_chk.sv]
`timescale 1ns/100ps
module dual_supply_reset_sequencer_chk #(
    parameter int unsigned TIMEOUT_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_ok,
    input wire logic secondary_monitor_input,
    input wire logic manual_reset_n,
    input wire logic delay_select_pin,
    input wire logic ramp_reached,
    input wire logic primary_reset_n,
    input wire logic secondary_reset_n
);
    logic [15:0] mlo_r, slo_r, rlo_r, ok_r, sok_r;
    // Run lengths of each condition; bounds below allow filter plus skew, filter alone for the secondary
    always_ff @(posedge clk) begin
        mlo_r <= (rst_n && !master_ok) ? mlo_r + 16'h1 : 16'h0;
        slo_r <= (rst_n && !secondary_monitor_input) ? slo_r + 16'h1 : 16'h0;
        rlo_r <= (rst_n && !manual_reset_n) ? rlo_r + 16'h1 : 16'h0;
        ok_r  <= (rst_n && master_ok && manual_reset_n) ? ok_r + 16'h1 : 16'h0;
        sok_r <= (rst_n && master_ok && manual_reset_n && secondary_monitor_input
                  && primary_reset_n) ? sok_r + 16'h1 : 16'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_master_forces: assert property (mlo_r > 16'h25d |-> !primary_reset_n && !secondary_reset_n)
        else $error("master fault left a reset released");
    chk_sec_forces: assert property (slo_r > 16'h069 |-> !secondary_reset_n)
        else $error("secondary fault left secondary released");
    chk_manual_forces: assert property (rlo_r > 16'h1fe |-> !primary_reset_n && !secondary_reset_n)
        else $error("manual reset left a reset released");
    chk_prim_cause: assert property ($fell(primary_reset_n) |-> mlo_r >= 16'h1f4 || rlo_r >= 16'h1f4)
        else $error("primary asserted without lasting cause");
    chk_sec_first: assert property ($fell(primary_reset_n) |-> !$past(secondary_reset_n, 8))
        else $error("primary asserted before secondary");
    chk_prim_timeout: assert property ($rose(primary_reset_n) |-> ok_r >= TIMEOUT_CYCLES)
        else $error("primary released early");
    chk_fixed_delay: assert property ($rose(secondary_reset_n) && $past(delay_select_pin, 2)
        |-> sok_r >= TIMEOUT_CYCLES)
        else $error("secondary released early");
    chk_ramp_release: assert property ($rose(secondary_reset_n) && !$past(delay_select_pin, 2)
        |-> $past(ramp_reached))
        else $error("secondary released before ramp end");
endmodule
bind dual_supply_reset_sequencer dual_supply_reset_sequencer_chk #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_chk (
    .clk(clk), .rst_n(rst_n), .master_ok(master_ok), .manual_reset_n(manual_reset_n),
    .secondary_monitor_input(secondary_monitor_input), .delay_select_pin(delay_select_pin),
    .ramp_reached(ramp_reached), .primary_reset_n(primary_reset_n),
    .secondary_reset_n(secondary_reset_n)
);

// [verification/ramp_cap_model.sv]
`timescale 1ns/100ps
module ramp_cap_model #(
    parameter int unsigned RAMP_CYCLES = 20
) (
    input  wire logic clk,
    input  wire logic charge_en,
    output logic      reached
);
    int unsigned level_r;
    // Discharge empties the ramp at once, so each delay starts from zero
    always_ff @(posedge clk) level_r <= charge_en ? level_r + 32'h1 : 32'h0;
    assign reached = (level_r >= RAMP_CYCLES);
endmodule

// [verification/tb_dual_supply_reset_sequencer.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_dual_supply_reset_sequencer;
    logic clk = 1'b0, rst_n = 1'b0, m_ok = 1'b1, m_deep = 1'b0, s_ok = 1'b1;
    logic mr_n = 1'b1, dsel = 1'b1, reached, prim_n, sec_n, chg;
    int   n_errors = 0, n_compared = 0;
    // Short timeout keeps every release within a few dozen cycles
    always #10 clk = ~clk;
    dual_supply_reset_sequencer #(.TIMEOUT_CYCLES(50)) u_dut (
        .clk(clk), .rst_n(rst_n), .master_ok(m_ok), .master_deep_low(m_deep),
        .secondary_monitor_input(s_ok), .secondary_deep_low(m_deep), .manual_reset_n(mr_n),
        .delay_select_pin(dsel), .ramp_reached(reached), .primary_reset_n(prim_n),
        .secondary_reset_n(sec_n), .ramp_charge_en(chg));
    ramp_cap_model u_cap (.clk(clk), .charge_en(chg), .reached(reached));
    task wait_cyc(input int n); repeat (n) @(negedge clk); endtask
    task pair(input logic p, input logic s);
        `CHK(prim_n, p)
        `CHK(sec_n, s)
    endtask
    task sec_back();
        wait_cyc(40);
        `CHK(sec_n, 1'b0)
        wait_cyc(20);
        `CHK(sec_n, 1'b1)
    endtask
    task recover();
        wait_cyc(45);
        pair(1'b0, 1'b0);
        wait_cyc(11);
        pair(1'b1, 1'b0);
        sec_back();
    endtask
    task t_power(); pair(1'b0, 1'b0); recover(); endtask
    task t_sec_dip();
        s_ok = 1'b0;
        wait_cyc(150);
        pair(1'b1, 1'b0);
        s_ok = 1'b1;
        sec_back();
    endtask
    // A shallow dip passes unseen; a deep one of the same order trips
    task t_glitch();
        m_ok = 1'b0;
        wait_cyc(50);
        m_ok = 1'b1;
        wait_cyc(5);
        pair(1'b1, 1'b1);
        {m_ok, m_deep} = 2'h1;
        wait_cyc(40);
        {m_ok, m_deep} = 2'h2;
        wait_cyc(2);
        pair(1'b1, 1'b0);
        sec_back();
    endtask
    task t_master();
        m_ok = 1'b0;
        wait_cyc(200);
        pair(1'b1, 1'b0);
        wait_cyc(450);
        pair(1'b0, 1'b0);
        m_ok = 1'b1;
        recover();
    endtask
    task t_manual();
        mr_n = 1'b0;
        wait_cyc(200);
        pair(1'b1, 1'b0);
        wait_cyc(400);
        pair(1'b0, 1'b0);
        mr_n = 1'b1;
        recover();
    endtask
    task t_ramp();
        {dsel, s_ok} = 2'h0;
        wait_cyc(150);
        s_ok = 1'b1;
        wait_cyc(5);
        `CHK(chg, 1'b1)
        wait_cyc(30);
        pair(1'b1, 1'b1);
        `CHK(chg, 1'b0)
        dsel = 1'b1;
    endtask
    task wrap_up();
        $display("Mismatches %0d, comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        wait_cyc(4);
        rst_n = 1'b1;
        t_power();
        t_sec_dip();
        t_glitch();
        t_master();
        t_manual();
        t_ramp();
        wrap_up();
    end
    // Whole sequence needs about 2150 cycles
    initial begin
        #100us;
        n_errors++;
        wrap_up();
    end
endmodule
